// >>> core/pecirq.sv
/*
 * Pin edge change interrupt core: per-pin rise and fall detection on four
 * ports, sticky change flags, summary flag, interrupt and sleep wake.
 * Every register is one aligned 32-bit word with its data in the low byte;
 * the byte address is four times the word index kept in the params header.
 * Each port owns three words in a row: change flags, fall enables and rise
 * enables. A control word, a read-only status word, a write-one-to-clear
 * interrupt status word and its mask follow the port words.
 * A pin change shows in its flag SYNC_STAGES+1 edges after it reaches the
 * pin; the wake request comes with the flag, the interrupt one edge later.
 * Every transfer answers with a one-cycle pready in its second access cycle.
 * Assumes an APB master on pclk, pin inputs asynchronous to pclk,
 * and a sleep indicator from the power controller.
 */
// How it works
// RULE_01: Every pin of all ports can detect
// RULE_02: Interrupt gated by global enable only; the code also gates it by irq_mask
// RULE_03: Rise detector enabled per pin bit
// RULE_04: Fall detector enabled per pin bit
// RULE_05: Both enables detect both edge directions
// RULE_06: Enabled edge sets pin flag, may interrupt
// RULE_07: Summary flag is OR of flags
// RULE_08: Writing zero clears a flag bit
// RULE_09: Edge during clearing write keeps flag
// RULE_10: Software clears flags by masked AND
// RULE_11: Enabled change sequence wakes from sleep
// RULE_12: Flags update before first wake instruction
// RULE_13: Flags reset zero, software RW, hardware set
// RULE_14: Reset pin or programming disables fourth
// RULE_15: Synchronise pins, compare samples, pulse edges
// RULE_16: Enable registers reset to zero
`timescale 1ns/100ps
`include "pecirq_params.svh"

module pecirq #(
    parameter int SYNC_STAGES = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pecirq_pkg::pecirq_pins_s pins,
    input wire logic sleep_active,
    output logic change_irq_summary_flag,
    output logic irq,
    output logic wake_req
);
    import pecirq_pkg::*;

    // Refuse a synchroniser too short to be safe or uselessly long;
    // checked while the design is elaborated, before any clock runs
    if (SYNC_STAGES < 2 || SYNC_STAGES > 4) begin : g_bad_sync
        $error("SYNC_STAGES must be 2 to 4");
    end

    // Word index of each per-port register base, flag first
    localparam logic [3:0][13:0] BASE_IDX = {
        `PECIRQ_IDX_E_FLAG,
        `PECIRQ_IDX_C_FLAG,
        `PECIRQ_IDX_B_FLAG,
        `PECIRQ_IDX_A_FLAG
    };

    // Synchroniser chain, one word per stage
    logic [SYNC_STAGES-1:0][3:0][7:0] sync_chain;
    // Last synchronised sample, one cycle old
    logic [3:0][7:0] prev_sample;
    // Raw pins gathered per port
    logic [3:0][7:0] raw_pins;
    // Pins that exist and are live
    logic [3:0][7:0] live_mask;
    // Per-port edge enables
    logic [3:0][7:0] rise_enable_reg;
    logic [3:0][7:0] fall_enable_reg;
    // Per-port change flags
    logic [3:0][7:0] change_flag_reg;
    logic [3:0][7:0] next_change_flag_reg;
    // One-cycle edge pulses
    logic [3:0][7:0] rise_pulse;
    logic [3:0][7:0] fall_pulse;
    logic [3:0][7:0] edge_pulse;
    // Control bits
    logic change_irq_enable;
    logic external_reset_pin_enable;
    logic low_voltage_programming;
    // Sticky interrupt status and its mask
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    // Any edge this cycle
    logic any_edge;
    // Address decode results
    logic [13:0] word_idx;
    logic port_hit;
    logic [1:0] hit_port;
    pecirq_reg_e hit_kind;
    logic ctrl_hit;
    logic stat_hit;
    logic irq_stat_hit;
    logic irq_mask_hit;
    logic addr_hit;
    // Bus strobes
    logic access_cycle;
    logic wr_commit;
    logic wr_lane0;
    logic [31:0] rd_value;

    // Gather raw pins; fourth port has its one pin at bit 3
    always_comb begin
        raw_pins[0] = pins.first_port;
        raw_pins[1] = pins.second_port;
        raw_pins[2] = pins.third_port;
        raw_pins[3] = {4'h0, pins.fourth_port_single_pin, 3'h0};
    end

    // Live pins: every pin of the first three ports, and the fourth
    // port pin only while no reset pin or programming function owns it
    // Enable writes use the same mask, so a missing pin is never armed
    always_comb begin
        live_mask[0] = `PECIRQ_MASK_FULL; // RULE_01
        live_mask[1] = `PECIRQ_MASK_FULL;
        live_mask[2] = `PECIRQ_MASK_FULL;
        if (external_reset_pin_enable || low_voltage_programming) begin
            live_mask[3] = `PECIRQ_RST_BYTE; // RULE_14
        end else begin
            live_mask[3] = `PECIRQ_MASK_E;
        end
    end

    // Synchroniser: stage 0 feeds stage 1 only
    // Only the last stage is read elsewhere, so a metastable stage stays inside
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_chain <= '0;
        end else if (ce) begin
            sync_chain[0] <= raw_pins; // RULE_15
            for (int s = 1; s < SYNC_STAGES; s++) begin
                sync_chain[s] <= sync_chain[s-1];
            end
        end
    end

    // Previous synchronised sample for edge comparison
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_sample <= '0;
        end else if (ce) begin
            prev_sample <= sync_chain[SYNC_STAGES-1]; // RULE_15
        end
    end

    // Edge detectors, each gated by its own enable bit
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            // Rising: low before, high now
            rise_pulse[p] = sync_chain[SYNC_STAGES-1][p] & ~prev_sample[p]
                & rise_enable_reg[p] & live_mask[p]; // RULE_03
            // Falling: high before, low now
            fall_pulse[p] = ~sync_chain[SYNC_STAGES-1][p] & prev_sample[p]
                & fall_enable_reg[p] & live_mask[p]; // RULE_04
            // Both enables give both directions
            edge_pulse[p] = rise_pulse[p] | fall_pulse[p]; // RULE_05
        end
        any_edge = |edge_pulse;
    end

    // Address decode over word index
    // The byte lanes of the address are dropped; a word that hits nothing
    // is answered with an error and changes no state
    always_comb begin
        word_idx = paddr[15:2];
        port_hit = 1'b0;
        hit_port = 2'h0;
        hit_kind = PECIRQ_FLAG;
        for (int p = 0; p < 4; p++) begin
            // Flag, fall and rise sit at base, base plus one, plus two
            if (word_idx == BASE_IDX[p]) begin
                port_hit = 1'b1;
                hit_port = 2'(p);
                hit_kind = PECIRQ_FLAG;
            end else if (word_idx == BASE_IDX[p] + 14'h0001) begin
                port_hit = 1'b1;
                hit_port = 2'(p);
                hit_kind = PECIRQ_FALL;
            end else if (word_idx == BASE_IDX[p] + 14'h0002) begin
                port_hit = 1'b1;
                hit_port = 2'(p);
                hit_kind = PECIRQ_RISE;
            end
        end
        ctrl_hit = (word_idx == `PECIRQ_IDX_CTRL);
        stat_hit = (word_idx == `PECIRQ_IDX_STAT);
        irq_stat_hit = (word_idx == `PECIRQ_IDX_IRQ_STAT);
        irq_mask_hit = (word_idx == `PECIRQ_IDX_IRQ_MASK);
        addr_hit = port_hit | ctrl_hit | stat_hit | irq_stat_hit | irq_mask_hit;
    end

    // Bus strobes: a write lands only at the edge that completes it
    always_comb begin
        access_cycle = psel & penable;
        wr_commit = access_cycle & pwrite & pready & addr_hit;
        wr_lane0 = wr_commit & pstrb[0];
    end

    // Read mux; bits above the register width read zero
    always_comb begin
        rd_value = 32'h0000_0000;
        if (port_hit) begin
            unique case (hit_kind)
                // Flags
                PECIRQ_FLAG: rd_value[7:0] = change_flag_reg[hit_port];
                // Fall enables
                PECIRQ_FALL: rd_value[7:0] = fall_enable_reg[hit_port];
                // Rise enables
                PECIRQ_RISE: rd_value[7:0] = rise_enable_reg[hit_port];
                default: rd_value[7:0] = `PECIRQ_RST_BYTE;
            endcase
        end else if (ctrl_hit) begin
            rd_value[`PECIRQ_CTRL_IRQ_EN] = change_irq_enable;
            rd_value[`PECIRQ_CTRL_EXT_RST] = external_reset_pin_enable;
            rd_value[`PECIRQ_CTRL_LV_PROG] = low_voltage_programming;
        end else if (stat_hit) begin
            rd_value[0] = change_irq_summary_flag;
        end else if (irq_stat_hit) begin
            rd_value[1:0] = irq_status;
        end else if (irq_mask_hit) begin
            rd_value[1:0] = irq_mask;
        end
    end

    // APB answer: ready one cycle into the access phase
    // A low clock enable freezes the answer, so the transfer just stretches;
    // the master holds its request until it sees the pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce) begin
            if (access_cycle && !pready) begin
                // Answer, flag unmapped addresses as errors
                pready <= 1'b1;
                prdata <= pwrite ? 32'h0000_0000 : rd_value;
                pslverr <= ~addr_hit;
            end else begin
                // Idle or transfer just completed
                pready <= 1'b0;
                prdata <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end

    // Edge enable registers
    // A fourth-port enable written while the pin belongs to the reset or
    // programming function is stored as zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_enable_reg <= '0; // RULE_16
            fall_enable_reg <= '0; // RULE_16
        end else if (ce && wr_lane0 && port_hit) begin
            if (hit_kind == PECIRQ_RISE) begin
                rise_enable_reg[hit_port] <= pwdata[7:0] & live_mask[hit_port];
            end else if (hit_kind == PECIRQ_FALL) begin
                fall_enable_reg[hit_port] <= pwdata[7:0] & live_mask[hit_port];
            end
        end
    end

    // Next flag value: software write first, then hardware set wins
    // An edge in the very cycle of a clearing write survives, so software
    // that clears by masked write never loses an edge
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            next_change_flag_reg[p] = change_flag_reg[p];
            // Writing zero clears, writing one sets
            if (wr_lane0 && port_hit && hit_kind == PECIRQ_FLAG
                    && hit_port == 2'(p)) begin
                next_change_flag_reg[p] = pwdata[7:0] & live_mask[p]; // RULE_08
            end
            // An edge in the write cycle still leaves its flag set
            next_change_flag_reg[p] = next_change_flag_reg[p] | edge_pulse[p]; // RULE_09
        end
    end

    // Change flag registers; clocked on every edge, asleep or not,
    // so a wake finds them already updated
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            change_flag_reg <= '0; // RULE_13
        end else if (ce) begin
            change_flag_reg <= next_change_flag_reg; // RULE_06 RULE_12
        end
    end

    // Summary flag follows the OR of all flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            change_irq_summary_flag <= 1'b0;
        end else if (ce) begin
            change_irq_summary_flag <= |next_change_flag_reg; // RULE_07
        end
    end

    // Control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            change_irq_enable <= 1'b0;
            external_reset_pin_enable <= 1'b0;
            low_voltage_programming <= 1'b0;
        end else if (ce && wr_lane0 && ctrl_hit) begin
            change_irq_enable <= pwdata[`PECIRQ_CTRL_IRQ_EN];
            external_reset_pin_enable <= pwdata[`PECIRQ_CTRL_EXT_RST];
            low_voltage_programming <= pwdata[`PECIRQ_CTRL_LV_PROG];
        end
    end

    // Interrupt mask register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= `PECIRQ_RST_IRQ;
        end else if (ce && wr_lane0 && irq_mask_hit) begin
            irq_mask <= pwdata[1:0];
        end
    end

    // Sticky interrupt status: write one clears, a new event wins
    // The wake bit records an edge seen while asleep with the enable set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= `PECIRQ_RST_IRQ;
        end else if (ce) begin
            // Edge event sets bit 0, wake event sets bit 1
            irq_status[`PECIRQ_IRQ_EDGE] <=
                (irq_status[`PECIRQ_IRQ_EDGE]
                 & ~(wr_lane0 & irq_stat_hit & pwdata[`PECIRQ_IRQ_EDGE]))
                | any_edge; // RULE_06
            irq_status[`PECIRQ_IRQ_WAKE] <=
                (irq_status[`PECIRQ_IRQ_WAKE]
                 & ~(wr_lane0 & irq_stat_hit & pwdata[`PECIRQ_IRQ_WAKE]))
                | (sleep_active & change_irq_enable & any_edge);
        end
    end

    // Interrupt line: only while the global enable is set
    // Status keeps collecting while the enable is clear, so nothing is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= change_irq_enable & (|(irq_status & irq_mask)); // RULE_02
        end
    end

    // Wake request: raised while asleep with a pending enabled change
    // Taken from the next flag value, so it rises with the flag itself
    // and the flags are already updated when the core resumes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_req <= 1'b0;
        end else if (ce) begin
            wake_req <= sleep_active & change_irq_enable
                & (|next_change_flag_reg); // RULE_11
        end
    end

endmodule

// >>> core/pecirq_params.svh
/*
 * Register indices, field positions, reset values and pin masks of the
 * pin edge change interrupt block.
 * Assumes it is included by its bare name from the package and the core.
 */
`ifndef PECIRQ_PARAMS_SVH
`define PECIRQ_PARAMS_SVH

// Word index of each register; byte address is four times the index
`define PECIRQ_IDX_A_FLAG 14'h0f05
`define PECIRQ_IDX_A_FALL 14'h0f06
`define PECIRQ_IDX_A_RISE 14'h0f07
`define PECIRQ_IDX_B_FLAG 14'h0f0d
`define PECIRQ_IDX_B_FALL 14'h0f0e
`define PECIRQ_IDX_B_RISE 14'h0f0f
`define PECIRQ_IDX_C_FLAG 14'h0f15
`define PECIRQ_IDX_C_FALL 14'h0f16
`define PECIRQ_IDX_C_RISE 14'h0f17
`define PECIRQ_IDX_E_FLAG 14'h0f22
`define PECIRQ_IDX_E_FALL 14'h0f23
`define PECIRQ_IDX_E_RISE 14'h0f24
`define PECIRQ_IDX_CTRL 14'h0f30
`define PECIRQ_IDX_STAT 14'h0f31
`define PECIRQ_IDX_IRQ_STAT 14'h0f32
`define PECIRQ_IDX_IRQ_MASK 14'h0f33

// Control register fields
`define PECIRQ_CTRL_IRQ_EN 0
`define PECIRQ_CTRL_EXT_RST 1
`define PECIRQ_CTRL_LV_PROG 2

// Interrupt status and mask fields
`define PECIRQ_IRQ_EDGE 0
`define PECIRQ_IRQ_WAKE 1

// Pins that exist on each port
`define PECIRQ_MASK_FULL 8'hff
`define PECIRQ_MASK_E 8'h08

// Reset values
`define PECIRQ_RST_BYTE 8'h00
`define PECIRQ_RST_CTRL 3'h0
`define PECIRQ_RST_IRQ 2'h0

`endif

// >>> core/pecirq_pkg.sv
/*
 * Types shared by the pin edge change interrupt block.
 * Assumes the params header sits beside it.
 */
`include "pecirq_params.svh"

package pecirq_pkg;
    // One 8-bit port worth of bits
    typedef logic [7:0] pecirq_byte_t;

    // Raw pin levels of all four ports
    typedef struct packed {
        logic fourth_port_single_pin;
        pecirq_byte_t third_port;
        pecirq_byte_t second_port;
        pecirq_byte_t first_port;
    } pecirq_pins_s;

    // Kind of per-port register
    typedef enum logic [1:0] {
        PECIRQ_FLAG,
        PECIRQ_FALL,
        PECIRQ_RISE
    } pecirq_reg_e;
endpackage

// >>> tb/pecirq_assertions.sv
/*
 * Port-level checker for the pin edge change interrupt block.
 * Assumes ce is held high and is bound from the testbench top file.
 */
`timescale 1ns/100ps
module pecirq_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire pecirq_pkg::pecirq_pins_s pins,
    input wire logic sleep_active,
    input wire logic change_irq_summary_flag,
    input wire logic irq,
    input wire logic wake_req
);
    import pecirq_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    pecirq_pins_s pins_q; // Pin levels one edge ago
    logic [4:0] chg_h; // Recent pin changes, newest in bit 0
    logic [2:0] wr_h; // Recent completed writes
    // History of pin changes and writes, the only causes of flag movement
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_q <= '0;
            chg_h <= '0;
            wr_h <= '0;
        end else begin
            pins_q <= pins;
            chg_h <= {chg_h[3:0], pins != pins_q};
            wr_h <= {wr_h[1:0], pready & pwrite};
        end
    end
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("pready without access");
    a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero when idle");
    a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0) else $error("prdata upper bits set");
    a_wake_asleep: assert property (wake_req |-> $past(sleep_active)) else $error("wake while awake");
    a_sum_rise: assert property ($rose(change_irq_summary_flag) |-> (|chg_h) || (|wr_h))
        else $error("summary rose without cause");
    a_sum_fall: assert property ($fell(change_irq_summary_flag) |-> |wr_h)
        else $error("summary fell without write");
    a_irq_cause: assert property ($rose(irq) |-> (|chg_h) || (|wr_h))
        else $error("irq rose without cause");
    c_irq: cover property ($rose(irq));
    c_wake: cover property ($rose(wake_req));
    c_err: cover property (pslverr);
endmodule

// >>> tb/pecirq_pin_model.sv
/*
 * Model of the external signals on the port pins.
 * Assumes calls come right after a rising pclk edge.
 */
`timescale 1ns/100ps
module pecirq_pin_model (
    input wire logic pclk,
    output pecirq_pkg::pecirq_pins_s pins
);
    import pecirq_pkg::*;
    // Quiet board: all pins low
    initial begin
        pins = '0;
    end
    // New levels land after the edge; the caller holds each level several cycles
    task automatic put(input pecirq_pins_s v);
        pins <= v;
    endtask
endmodule

// >>> tb/tb.sv
/*
 * Self-checking testbench for the pin edge change interrupt block.
 * Assumes the core, its package and header are compiled first.
 */
`timescale 1ns/100ps
`include "pecirq_params.svh"
module tb;
    import pecirq_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, sleep_active;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic pready, pslverr, sum_flag, irq, wake_req;
    pecirq_pins_s pins, pv; // Pins on the wire, levels wanted next
    int miscompares = 0;
    int checks = 0;
    int cyc = 0;
    pecirq_pin_model pm (.pclk(pclk), .pins(pins));
    pecirq uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pins(pins), .sleep_active(sleep_active), .change_irq_summary_flag(sum_flag), .irq(irq), .wake_req(wake_req));
    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [13:0] i, input logic [7:0] d, output logic [31:0] rd,
        output logic er);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so the next call never re-raises psel in this time step
        @(posedge pclk);
    endtask
    task automatic wr(input logic [13:0] i, input logic [7:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, i, d, rd, er);
    endtask
    task automatic rdc(input logic [13:0] i, input logic [7:0] e, input string n);
        logic [31:0] rd;
        logic er;
        apb(1'b0, i, 8'h00, rd, er);
        chk(n, rd, {24'h0, e});
    endtask
    // Drive new levels and let them pass synchroniser and detector
    task automatic pin();
        pm.put(pv);
        repeat (4) @(posedge pclk);
    endtask
    task automatic t_reset();
        logic [13:0] base[4] = '{`PECIRQ_IDX_A_FLAG, `PECIRQ_IDX_B_FLAG, `PECIRQ_IDX_C_FLAG, `PECIRQ_IDX_E_FLAG};
        logic [31:0] rd;
        logic er;
        foreach (base[k]) for (int j = 0; j < 3; j++) rdc(base[k] + 14'(j), 8'h00, "reset reg");
        rdc(`PECIRQ_IDX_CTRL, 8'h00, "reset ctrl");
        apb(1'b0, 14'h0f08, 8'h00, rd, er);
        chk("unmapped err", {31'h0, er}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        // A write without the low byte strobe must leave the register alone
        pstrb <= 4'he;
        wr(`PECIRQ_IDX_CTRL, 8'h07);
        pstrb <= 4'hf;
        rdc(`PECIRQ_IDX_CTRL, 8'h00, "strobe off");
        $display("test reset done");
    endtask
    task automatic t_edges();
        logic [31:0] rd;
        logic er;
        wr(`PECIRQ_IDX_A_RISE, 8'h05);
        wr(`PECIRQ_IDX_A_FALL, 8'h06);
        pv.first_port = 8'h07;
        pin();
        rdc(`PECIRQ_IDX_A_FLAG, 8'h05, "rise flags");
        chk("summary set", {31'h0, sum_flag}, 32'h1);
        rdc(`PECIRQ_IDX_STAT, 8'h01, "status reg");
        wr(`PECIRQ_IDX_A_FLAG, 8'h00);
        rdc(`PECIRQ_IDX_A_FLAG, 8'h00, "cleared");
        chk("summary clear", {31'h0, sum_flag}, 32'h0);
        pv.first_port = 8'h00;
        pin();
        rdc(`PECIRQ_IDX_A_FLAG, 8'h06, "fall flags");
        wr(`PECIRQ_IDX_A_FLAG, 8'h00);
        wr(`PECIRQ_IDX_B_RISE, 8'hff);
        wr(`PECIRQ_IDX_C_FALL, 8'hff);
        pv.second_port = 8'hff;
        pv.third_port = 8'hff;
        pin();
        rdc(`PECIRQ_IDX_C_FLAG, 8'h00, "no rise c");
        pv.third_port = 8'h00;
        pin();
        rdc(`PECIRQ_IDX_C_FLAG, 8'hff, "fall c");
        wr(`PECIRQ_IDX_C_FLAG, 8'h00);
        apb(1'b0, `PECIRQ_IDX_B_FLAG, 8'h00, rd, er);
        chk("rise b", rd, 32'hff);
        wr(`PECIRQ_IDX_B_FLAG, rd[7:0] & (rd[7:0] ^ 8'hff));
        rdc(`PECIRQ_IDX_B_FLAG, 8'h00, "masked clear");
        $display("test edges done");
    endtask
    task automatic t_irq();
        wr(`PECIRQ_IDX_IRQ_MASK, 8'h01);
        rdc(`PECIRQ_IDX_IRQ_MASK, 8'h01, "mask reg");
        pv.first_port = 8'h01;
        pin();
        chk("irq gated", {31'h0, irq}, 32'h0);
        rdc(`PECIRQ_IDX_A_FLAG, 8'h01, "flag gated");
        wr(`PECIRQ_IDX_CTRL, 8'h01);
        repeat (2) @(posedge pclk);
        chk("irq on", {31'h0, irq}, 32'h1);
        wr(`PECIRQ_IDX_IRQ_MASK, 8'h00);
        repeat (2) @(posedge pclk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(`PECIRQ_IDX_IRQ_MASK, 8'h01);
        wr(`PECIRQ_IDX_IRQ_STAT, 8'h01);
        repeat (2) @(posedge pclk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        wr(`PECIRQ_IDX_A_FLAG, 8'h00);
        // Edge lands on the same edge as a clearing write
        pv.first_port = 8'h05;
        pm.put(pv);
        wr(`PECIRQ_IDX_A_FLAG, 8'h00);
        rdc(`PECIRQ_IDX_A_FLAG, 8'h04, "edge kept");
        wr(`PECIRQ_IDX_A_FLAG, 8'h00);
        $display("test irq done");
    endtask
    task automatic t_fourth();
        logic [7:0] off[2] = '{8'h03, 8'h05};
        wr(`PECIRQ_IDX_E_RISE, 8'h08);
        foreach (off[k]) begin
            wr(`PECIRQ_IDX_CTRL, off[k]);
            pv.fourth_port_single_pin = 1'b1;
            pin();
            pv.fourth_port_single_pin = 1'b0;
            pin();
            rdc(`PECIRQ_IDX_E_FLAG, 8'h00, "fourth off");
        end
        wr(`PECIRQ_IDX_CTRL, 8'h01);
        pv.fourth_port_single_pin = 1'b1;
        pin();
        rdc(`PECIRQ_IDX_E_FLAG, 8'h08, "fourth on");
        wr(`PECIRQ_IDX_E_FLAG, 8'h00);
        $display("test fourth done");
    endtask
    task automatic t_sleep();
        wr(`PECIRQ_IDX_IRQ_STAT, 8'h03);
        sleep_active <= 1'b1;
        pv.first_port = 8'h01;
        pin();
        chk("wake", {31'h0, wake_req}, 32'h1);
        rdc(`PECIRQ_IDX_A_FLAG, 8'h04, "flag at wake");
        rdc(`PECIRQ_IDX_IRQ_STAT, 8'h03, "wake event");
        sleep_active <= 1'b0;
        wr(`PECIRQ_IDX_A_FLAG, 8'h00);
        chk("awake", {31'h0, wake_req}, 32'h0);
        $display("test sleep done");
    endtask
    // Main sequence
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, sleep_active} = 4'h0;
        paddr = 16'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        pv = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_edges();
        t_irq();
        t_fourth();
        t_sleep();
        end_of_test();
    end
endmodule
bind pecirq pecirq_assertions chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
    .pins, .sleep_active, .change_irq_summary_flag, .irq, .wake_req);
